//--- hw/apm_pkg.sv
package apm_pkg;

    // Register word indices and byte addresses (index times four)
    localparam logic [7:0] IDX_INACT_LEVEL    = 8'h25;
    localparam logic [7:0] IDX_INACT_DUR      = 8'h26;
    localparam logic [7:0] IDX_RATE_SELECT    = 8'h2c;
    localparam logic [7:0] IDX_POWER_CONTROL  = 8'h2d;
    localparam logic [7:0] IDX_AUX_CTL        = 8'h30;
    localparam logic [7:0] IDX_STATUS         = 8'h31;
    localparam logic [7:0] ADDR_INACT_LEVEL   = 8'h94;
    localparam logic [7:0] ADDR_INACT_DUR     = 8'h98;
    localparam logic [7:0] ADDR_RATE_SELECT   = 8'hb0;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'hb4;
    localparam logic [7:0] ADDR_AUX_CTL       = 8'hc0;
    localparam logic [7:0] ADDR_STATUS        = 8'hc4;

    // Field positions
    localparam int POS_MEASURE    = 3;
    localparam int POS_AUTO_SLEEP = 4;
    localparam int POS_LINK       = 5;
    localparam int POS_LOW_POWER  = 4;
    localparam int POS_SELF_TEST  = 0;

    // Reset values
    localparam logic [7:0] RST_INACT_LEVEL = 8'h00;
    localparam logic [7:0] RST_INACT_DUR   = 8'h00;
    localparam logic [7:0] RST_RATE_SELECT = 8'h0a;
    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;

    // Rate codes
    localparam logic [3:0] CODE_TOP   = 4'hf;
    localparam logic [3:0] CODE_SLEEP = 4'h6;

    // Timing
    localparam int CLK_HZ      = 40_000_000;
    localparam int ODR_TOP_HZ  = 3200;
    localparam int BASE_CYCLES = CLK_HZ / ODR_TOP_HZ;
    localparam int TIMER_W     = 29;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        APM_STANDBY,
        APM_MEASURE,
        APM_SLEEP
    } apm_mode_e;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } apm_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } apm_axi_rsp_s;

endpackage

//--- hw/apm_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module apm_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    meta[i] <= 1'b0;
                    q[i]    <= 1'b0;
                end else if (ce) begin
                    meta[i] <= d[i];
                    q[i]    <= meta[i];
                end
            end
        end
    endgenerate
endmodule // apm_sync2
`default_nettype wire

//--- hw/apm_rate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module apm_rate_timer #(
    parameter int BASE_CYCLES = apm_pkg::BASE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [3:0] code,
    output logic            tick
);
    logic [apm_pkg::TIMER_W-1:0] count;
    logic [apm_pkg::TIMER_W-1:0] limit;
    logic [3:0]                  code_q;
    logic [3:0]                  shift;

    // Each lower code doubles the period
    always_comb begin
        shift = apm_pkg::CODE_TOP - code;
        limit = (apm_pkg::TIMER_W'(BASE_CYCLES) << shift) - apm_pkg::TIMER_W'(1);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count  <= '0;
            code_q <= 4'h0;
            tick   <= 1'b0;
        end else if (ce) begin
            code_q <= code;
            tick   <= 1'b0;
            if (!run || code != code_q) begin
                count <= '0;
            end else if (count >= limit) begin
                count <= '0;
                tick  <= 1'b1;
            end else begin
                count <= count + apm_pkg::TIMER_W'(1);
            end
        end
    end
endmodule // apm_rate_timer
`default_nettype wire

//--- hw/apm_power_ctrl.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - After reset the block sits in standby with sensing off.
// - Setting power_control bit 3 moves standby into measurement.
// - Clearing the measure bit returns the block to standby.
// - Every register stays readable in standby, and all but status stay writable.
// - Four-bit rate code; 1111 is 3200 Hz, each step lower halves.
// - rate_select bit 4 selects low power, reduced internal sampling.
// - Auto sleep drops to sub-12.5 Hz sampling on inactivity.
// - No samples are requested in standby after its first cycle.
// - Entering standby holds the sample buffer, keeping its contents.
// - Self test only runs with low power cleared.
module apm_power_ctrl #(
    parameter int BASE_CYCLES = apm_pkg::BASE_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire apm_pkg::apm_axi_req_s s_axi_req,
    output apm_pkg::apm_axi_rsp_s      s_axi_rsp,
    input  wire logic                  inact_det,
    input  wire logic                  act_det,
    output logic                       sample_req,
    output logic                       low_power_on,
    output logic                       self_test_on,
    output logic                       buffer_hold,
    output logic                       sensing_on,
    output logic [7:0]                 inact_level_out,
    output logic [7:0]                 inact_dur_out
);

    typedef struct packed {
        apm_pkg::apm_mode_e mode;
        logic [7:0]         inact_level;
        logic [7:0]         inact_dur;
        logic [7:0]         rate;
        logic [7:0]         pctl;
        logic               self_test;
        logic               aw_got;
        logic [7:0]         awaddr;
        logic               w_got;
        logic [7:0]         wdata;
        logic               wlane0;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic               sample_req;
        logic               low_power_on;
        logic               self_test_on;
        logic               buffer_hold;
        logic               sensing_on;
        logic [15:0]        sample_cnt;
    } apm_core_s;

    apm_core_s  cur;
    apm_core_s  next_cur;
    logic [1:0] det_s;
    logic       tick;
    logic [3:0] eff_code;
    logic       run;

    apm_sync2 #(
        .W (2)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .d       ({act_det, inact_det}),
        .q       (det_s)
    );

    // Sleep runs on the slow fixed code
    always_comb begin
        run      = (cur.mode != apm_pkg::APM_STANDBY);
        eff_code = (cur.mode == apm_pkg::APM_SLEEP) ? apm_pkg::CODE_SLEEP : cur.rate[3:0];
    end

    apm_rate_timer #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .run     (run),
        .code    (eff_code),
        .tick    (tick)
    );

    function automatic logic [31:0] read_word(input apm_core_s s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            apm_pkg::ADDR_INACT_LEVEL: v = {24'h00_0000, s.inact_level};
            apm_pkg::ADDR_INACT_DUR:   v = {24'h00_0000, s.inact_dur};
            apm_pkg::ADDR_RATE_SELECT: v = {24'h00_0000, s.rate};
            apm_pkg::ADDR_POWER_CONTROL: v = {24'h00_0000, s.pctl};
            apm_pkg::ADDR_AUX_CTL:     v = {31'h0000_0000, s.self_test};
            apm_pkg::ADDR_STATUS:      v = {14'h0000, s.mode, s.sample_cnt};
            default:                   v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        logic m;
        m = 1'b0;
        case (a)
            apm_pkg::ADDR_INACT_LEVEL,
            apm_pkg::ADDR_INACT_DUR,
            apm_pkg::ADDR_RATE_SELECT,
            apm_pkg::ADDR_POWER_CONTROL,
            apm_pkg::ADDR_AUX_CTL,
            apm_pkg::ADDR_STATUS:      m = 1'b1;
            default:                   m = 1'b0;
        endcase
        return m;
    endfunction

    always_comb begin
        next_cur = cur;

        // Write address and data, taken in either order
        if (s_axi_req.awvalid && cur.awready) begin
            next_cur.aw_got = 1'b1;
            next_cur.awaddr = s_axi_req.awaddr;
        end
        if (s_axi_req.wvalid && cur.wready) begin
            next_cur.w_got  = 1'b1;
            next_cur.wdata  = s_axi_req.wdata[7:0];
            next_cur.wlane0 = s_axi_req.wstrb[0];
        end
        if (cur.bvalid && s_axi_req.bready) begin
            next_cur.bvalid = 1'b0;
        end

        // Registers accept writes in every mode
        if (cur.aw_got && cur.w_got && !cur.bvalid) begin
            next_cur.aw_got = 1'b0;
            next_cur.w_got  = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp  = mapped(cur.awaddr) ? apm_pkg::RESP_OKAY : apm_pkg::RESP_SLVERR;
            if (cur.wlane0) begin
                case (cur.awaddr)
                    apm_pkg::ADDR_INACT_LEVEL: next_cur.inact_level = cur.wdata;
                    apm_pkg::ADDR_INACT_DUR:   next_cur.inact_dur = cur.wdata;
                    apm_pkg::ADDR_RATE_SELECT: next_cur.rate = cur.wdata;
                    apm_pkg::ADDR_POWER_CONTROL: next_cur.pctl = cur.wdata;
                    apm_pkg::ADDR_AUX_CTL:     next_cur.self_test = cur.wdata[apm_pkg::POS_SELF_TEST];
                    default:                   next_cur.pctl = cur.pctl;
                endcase
            end
        end

        // Read path, answer one cycle after the address
        if (s_axi_req.arvalid && cur.arready) begin
            next_cur.rvalid = 1'b1;
            next_cur.rdata  = read_word(cur, s_axi_req.araddr);
            next_cur.rresp  = mapped(s_axi_req.araddr) ? apm_pkg::RESP_OKAY : apm_pkg::RESP_SLVERR;
        end else if (cur.rvalid && s_axi_req.rready) begin
            next_cur.rvalid = 1'b0;
        end

        next_cur.awready = !next_cur.aw_got && !next_cur.bvalid;
        next_cur.wready  = !next_cur.w_got && !next_cur.bvalid;
        next_cur.arready = !next_cur.rvalid;

        // Power mode sequencing
        case (cur.mode)
            apm_pkg::APM_STANDBY: begin
                if (cur.pctl[apm_pkg::POS_MEASURE]) begin
                    next_cur.mode = apm_pkg::APM_MEASURE;
                end
            end
            apm_pkg::APM_MEASURE: begin
                if (!cur.pctl[apm_pkg::POS_MEASURE]) begin
                    next_cur.mode = apm_pkg::APM_STANDBY;
                end else if (cur.pctl[apm_pkg::POS_AUTO_SLEEP] && det_s[0]) begin
                    next_cur.mode = apm_pkg::APM_SLEEP;
                end
            end
            apm_pkg::APM_SLEEP: begin
                if (!cur.pctl[apm_pkg::POS_MEASURE]) begin
                    next_cur.mode = apm_pkg::APM_STANDBY;
                end else if (!cur.pctl[apm_pkg::POS_AUTO_SLEEP]) begin
                    next_cur.mode = apm_pkg::APM_MEASURE;
                end else if (cur.pctl[apm_pkg::POS_LINK] && det_s[1]) begin
                    next_cur.mode = apm_pkg::APM_MEASURE;
                end
            end
            default: begin
                next_cur.mode = apm_pkg::APM_STANDBY;
            end
        endcase

        // One sample per data period outside standby
        next_cur.sample_req = 1'b0;
        if (tick && cur.mode != apm_pkg::APM_STANDBY) begin
            next_cur.sample_req = 1'b1;
            next_cur.sample_cnt = cur.sample_cnt + 16'h0001;
        end

        next_cur.sensing_on   = (next_cur.mode != apm_pkg::APM_STANDBY);
        next_cur.buffer_hold  = (next_cur.mode == apm_pkg::APM_STANDBY);
        next_cur.low_power_on = next_cur.sensing_on
                                && next_cur.rate[apm_pkg::POS_LOW_POWER];
        next_cur.self_test_on = next_cur.self_test && next_cur.sensing_on
                                && !next_cur.rate[apm_pkg::POS_LOW_POWER];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur             <= '0;
            cur.mode        <= apm_pkg::APM_STANDBY;
            cur.inact_level <= apm_pkg::RST_INACT_LEVEL;
            cur.inact_dur   <= apm_pkg::RST_INACT_DUR;
            cur.rate        <= apm_pkg::RST_RATE_SELECT;
            cur.pctl        <= apm_pkg::RST_POWER_CONTROL;
            cur.buffer_hold <= 1'b1;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    always_comb begin
        s_axi_rsp.awready = cur.awready;
        s_axi_rsp.wready  = cur.wready;
        s_axi_rsp.bvalid  = cur.bvalid;
        s_axi_rsp.bresp   = cur.bresp;
        s_axi_rsp.arready = cur.arready;
        s_axi_rsp.rvalid  = cur.rvalid;
        s_axi_rsp.rdata   = cur.rdata;
        s_axi_rsp.rresp   = cur.rresp;
        sample_req        = cur.sample_req;
        low_power_on      = cur.low_power_on;
        self_test_on      = cur.self_test_on;
        buffer_hold       = cur.buffer_hold;
        sensing_on        = cur.sensing_on;
        inact_level_out   = cur.inact_level;
        inact_dur_out     = cur.inact_dur;
    end

endmodule // apm_power_ctrl
`default_nettype wire

//--- verification/apm_host.sv
`timescale 1ns/1ps
`default_nettype none
module apm_host (
    input  wire logic                  clk,
    output var apm_pkg::apm_axi_req_s  req,
    input  wire apm_pkg::apm_axi_rsp_s rsp
);
    initial req = '0;
    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge clk);
        req.awaddr  <= a;
        req.wdata   <= v;
        req.wstrb   <= s;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready && req.awvalid) begin
                req.awvalid <= 1'b0;
                req.awaddr  <= ~a;
            end
            if (rsp.wready && req.wvalid) begin
                req.wvalid <= 1'b0;
                req.wdata  <= ~v;
            end
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    // Read: rready held until the answer is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready && req.arvalid) begin
                req.arvalid <= 1'b0;
                req.araddr  <= ~a;
            end
        end while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
endmodule // apm_host
`default_nettype wire

//--- verification/apm_power_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module apm_power_ctrl_checker #(
    parameter int BASE_CYCLES = apm_pkg::BASE_CYCLES
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire apm_pkg::apm_axi_req_s s_axi_req,
    input wire apm_pkg::apm_axi_rsp_s s_axi_rsp,
    input wire logic                  sample_req,
    input wire logic                  low_power_on,
    input wire logic                  self_test_on,
    input wire logic                  buffer_hold,
    input wire logic                  sensing_on,
    input wire logic [7:0]            inact_level_out
);
    logic [7:0]  aw_a;
    logic [7:0]  w_d;
    logic        w_s;
    logic [7:0]  ar_a;
    logic [15:0] gap;
    always_ff @(posedge clk) begin
        if (s_axi_req.awvalid && s_axi_rsp.awready) aw_a <= s_axi_req.awaddr;
        if (s_axi_req.wvalid && s_axi_rsp.wready) w_d <= s_axi_req.wdata[7:0];
        if (s_axi_req.wvalid && s_axi_rsp.wready) w_s <= s_axi_req.wstrb[0];
        if (s_axi_req.arvalid && s_axi_rsp.arready) ar_a <= s_axi_req.araddr;
        if (sys_rst || sample_req) gap <= 16'h0001;
        else if (gap != 16'hffff) gap <= gap + 16'h0001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_reset_idle;
        $past(sys_rst) |-> buffer_hold && !sensing_on && !sample_req;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_hold_mirror;
        buffer_hold != sensing_on;
    endproperty
    a_hold_mirror: assert property (p_hold_mirror) else $error("hold and sensing agree");
    property p_quiet_standby;
        buffer_hold && $past(buffer_hold) |-> !sample_req;
    endproperty
    a_quiet_standby: assert property (p_quiet_standby) else $error("sample in standby");
    property p_measure_bit;
        $rose(s_axi_rsp.bvalid) && aw_a == apm_pkg::ADDR_POWER_CONTROL && w_s
            |-> ##[1:3] sensing_on == w_d[3];
    endproperty
    a_measure_bit: assert property (p_measure_bit) else $error("mode ignores measure bit");
    property p_level_read;
        $rose(s_axi_rsp.rvalid) && ar_a == apm_pkg::ADDR_INACT_LEVEL
            |-> s_axi_rsp.rdata == {24'h0, inact_level_out};
    endproperty
    a_level_read: assert property (p_level_read) else $error("level read mismatch");
    property p_low_power;
        low_power_on |-> sensing_on;
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power in standby");
    property p_self_test;
        self_test_on |-> sensing_on && !low_power_on;
    endproperty
    a_self_test: assert property (p_self_test) else $error("self test in low power");
    property p_period;
        sample_req |-> gap >= BASE_CYCLES;
    endproperty
    a_period: assert property (p_period) else $error("samples too close");
endmodule // apm_power_ctrl_checker
bind apm_power_ctrl apm_power_ctrl_checker #(.BASE_CYCLES(BASE_CYCLES)) u_checker (
    .clk(clk), .sys_rst(sys_rst), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
    .sample_req(sample_req), .low_power_on(low_power_on), .self_test_on(self_test_on),
    .buffer_hold(buffer_hold), .sensing_on(sensing_on), .inact_level_out(inact_level_out)
);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BASE = 4;
    logic                  clk;
    logic                  sys_rst;
    logic                  ce;
    logic                  inact_det;
    logic                  act_det;
    logic                  sample_req;
    logic                  low_power_on;
    logic                  self_test_on;
    logic                  buffer_hold;
    logic                  sensing_on;
    logic [7:0]            lvl;
    logic [7:0]            dur;
    logic [31:0]           d;
    logic [1:0]            r;
    int                    fails;
    int                    comparisons;
    int                    n;
    apm_pkg::apm_axi_req_s req;
    apm_pkg::apm_axi_rsp_s rsp;
    apm_power_ctrl #(.BASE_CYCLES(BASE)) u_apm_power_ctrl (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .s_axi_req(req), .s_axi_rsp(rsp),
        .inact_det(inact_det), .act_det(act_det), .sample_req(sample_req),
        .low_power_on(low_power_on), .self_test_on(self_test_on), .buffer_hold(buffer_hold),
        .sensing_on(sensing_on), .inact_level_out(lvl), .inact_dur_out(dur)
    );
    apm_host u_apm_host (.clk(clk), .req(req), .rsp(rsp));
    always #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_apm_host.wr(a, {24'h0, v}, 4'hf, r);
    endtask
    task automatic rd(input logic [7:0] a);
        u_apm_host.rd(a, d, r);
    endtask
    task automatic pulse();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sample_req !== 1'b1 && n < 9000);
    endtask
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask
    task automatic t_reset();
        settle();
        chk({sensing_on, buffer_hold, sample_req}, 3'b010);
        rd(apm_pkg::ADDR_POWER_CONTROL);
        chk(d, {24'h0, apm_pkg::RST_POWER_CONTROL});
        rd(apm_pkg::ADDR_RATE_SELECT);
        chk(d, {24'h0, apm_pkg::RST_RATE_SELECT});
        rd(apm_pkg::ADDR_STATUS);
        chk(d[17:16], 2'h0);
        $display("test reset done");
    endtask
    task automatic t_regs();
        logic [7:0] a [3] = '{apm_pkg::ADDR_INACT_LEVEL, apm_pkg::ADDR_INACT_DUR,
                              apm_pkg::ADDR_RATE_SELECT};
        logic [7:0] v [3] = '{8'ha5, 8'h3c, 8'h17};
        for (int i = 0; i < 3; i++) begin
            u_apm_host.wr(a[i], {24'hffffff, v[i]}, 4'hf, r);
            rd(a[i]);
            chk(d, {24'h0, v[i]});
        end
        chk({lvl, dur}, 16'ha53c);
        u_apm_host.wr(apm_pkg::ADDR_INACT_LEVEL, 32'h11, 4'he, r);
        chk(r, apm_pkg::RESP_OKAY);
        rd(apm_pkg::ADDR_INACT_LEVEL);
        chk(d, 32'ha5);
        wr(8'h00, 8'h01);
        chk(r, apm_pkg::RESP_SLVERR);
        rd(8'h00);
        chk(d, 32'h0);
        chk(r, apm_pkg::RESP_SLVERR);
        $display("test registers done");
    endtask
    task automatic t_rates();
        for (int c = 15; c >= 11; c--) begin
            wr(apm_pkg::ADDR_RATE_SELECT, 8'(c));
            wr(apm_pkg::ADDR_POWER_CONTROL, 8'h08);
            pulse();
            pulse();
            chk(n, BASE << (15 - c));
            chk({sensing_on, buffer_hold}, 2'b10);
            wr(apm_pkg::ADDR_POWER_CONTROL, 8'h00);
            settle();
            chk({sensing_on, buffer_hold}, 2'b01);
            n = 0;
            repeat (300) begin
                @(negedge clk);
                if (sample_req !== 1'b0) n++;
            end
            chk(n, 0);
        end
        $display("test rates done");
    endtask
    task automatic t_low_power();
        wr(apm_pkg::ADDR_RATE_SELECT, 8'h17);
        wr(apm_pkg::ADDR_AUX_CTL, 8'h01);
        wr(apm_pkg::ADDR_POWER_CONTROL, 8'h08);
        settle();
        chk({low_power_on, self_test_on}, 2'b10);
        wr(apm_pkg::ADDR_RATE_SELECT, 8'h07);
        settle();
        chk({low_power_on, self_test_on}, 2'b01);
        wr(apm_pkg::ADDR_POWER_CONTROL, 8'h00);
        wr(apm_pkg::ADDR_AUX_CTL, 8'h00);
        settle();
        chk({low_power_on, self_test_on}, 2'b00);
        $display("test low power done");
    endtask
    task automatic t_sleep();
        wr(apm_pkg::ADDR_INACT_LEVEL, 8'h10);
        wr(apm_pkg::ADDR_INACT_DUR, 8'h05);
        wr(apm_pkg::ADDR_RATE_SELECT, 8'h0f);
        wr(apm_pkg::ADDR_POWER_CONTROL, 8'h38);
        @(posedge clk);
        inact_det <= 1'b1;
        settle();
        rd(apm_pkg::ADDR_STATUS);
        chk(d[17:16], 2'h2);
        pulse();
        pulse();
        chk(n, BASE << (15 - apm_pkg::CODE_SLEEP));
        @(posedge clk);
        inact_det <= 1'b0;
        act_det   <= 1'b1;
        settle();
        rd(apm_pkg::ADDR_STATUS);
        chk(d[17:16], 2'h1);
        wr(apm_pkg::ADDR_POWER_CONTROL, 8'h00);
        act_det <= 1'b0;
        settle();
        chk(buffer_hold, 1'b1);
        $display("test sleep done");
    endtask
    task automatic t_freeze();
        wr(apm_pkg::ADDR_RATE_SELECT, 8'h0f);
        wr(apm_pkg::ADDR_POWER_CONTROL, 8'h08);
        pulse();
        @(posedge clk);
        ce <= 1'b0;
        n = 0;
        repeat (40) begin
            @(negedge clk);
            if (sample_req !== 1'b0) n++;
        end
        chk(n, 0);
        @(posedge clk);
        ce <= 1'b1;
        pulse();
        pulse();
        chk(n, BASE);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        settle();
        chk({sensing_on, buffer_hold, sample_req}, 3'b010);
        rd(apm_pkg::ADDR_POWER_CONTROL);
        chk(d, {24'h0, apm_pkg::RST_POWER_CONTROL});
        $display("test freeze and reset done");
    endtask
    initial begin
        clk       = 1'b0;
        sys_rst   = 1'b1;
        ce        = 1'b1;
        inact_det = 1'b0;
        act_det   = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_rates();
        t_low_power();
        t_sleep();
        t_freeze();
        close_out();
    end
    initial begin
        #(25 * 50000);
        fails++;
        close_out();
    end
endmodule // tb_top
`default_nettype wire
